// ### dv/tb_top.sv
// tb_top: register map, line status and receive interrupt tests
// assumes: usr_regs alone, host model on the bus, bench as receiver/transmitter
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    samples_checked++; \
    if ((got) !== (ex)) \
    begin \
      n_errors++; \
      $display("unexpected %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb_top;
  localparam logic [7:0] ID_V  = 8'h3C; // arbitrary value
  localparam logic [7:0] REV_V = 8'h07; // arbitrary value
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cs_n, rd_n, wr_n;
  logic [2:0]  addr;
  logic [7:0]  data_i, data_o, modem_ctrl, divisor_frac;
  logic [7:0]  line_ctrl, enh_func;
  logic [31:0] flow_chars;
  logic [1:0]  tx_trig_sel;
  logic        irq;
  logic [15:0] divisor;
  logic        rx_valid = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic        rx_perr = 1'b0;
  logic        rx_ferr = 1'b0;
  logic        rx_brk = 1'b0;
  logic        tx_fifo_empty = 1'b1;
  logic        tx_shift_empty = 1'b1;
  logic [7:0]  modem_stat = 8'h00;
  int          n_errors = 0;
  int          samples_checked = 0;

  usr_regs #(.DEV_ID(ID_V), .DEV_REV(REV_V)) i_usr_regs (
    .clk(clk), .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .data_i(data_i), .data_o(data_o), .data_oe(), .irq(irq),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_perr(rx_perr), .rx_ferr(rx_ferr),
    .rx_brk(rx_brk), .tx_fifo_empty(tx_fifo_empty), .tx_shift_empty(tx_shift_empty),
    .tx_wr(), .tx_data(), .tx_fifo_rst(), .line_ctrl(line_ctrl), .modem_ctrl(modem_ctrl),
    .enh_func(enh_func), .divisor(divisor), .divisor_frac(divisor_frac),
    .tx_trig_sel(tx_trig_sel), .flow_chars(flow_chars), .modem_stat(modem_stat));

  usr_host_model i_usr_host_model (
    .clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .wdata(data_i), .rdata(data_o));

  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    i_usr_host_model.wr(a, d);
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] ex);
    logic [7:0] v;
    i_usr_host_model.rd(a, v);
    `CHK($sformatf("read %0h", a), ex, v);
  endtask

  // one receive push; f is {break, framing, parity}
  task automatic push(input logic [7:0] d, input logic [2:0] f);
    @(negedge clk);
    rx_valid = 1'b1;
    rx_data = d;
    {rx_brk, rx_ferr, rx_perr} = f;
    @(negedge clk);
    rx_valid = 1'b0;
    {rx_brk, rx_ferr, rx_perr} = 3'h0;
  endtask

  task automatic irq_is(input logic ex);
    @(negedge clk);
    `CHK("irq", ex, irq);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    rchk(usr_pkg::OFF_LSR, 8'h60);
    tx_shift_empty = 1'b0;
    rchk(usr_pkg::OFF_LSR, 8'h20);
    tx_shift_empty = 1'b1;
    // register select and channel select
    wr(usr_pkg::OFF_SPR, 8'h5A);
    i_usr_host_model.mute = 1'b1;
    wr(usr_pkg::OFF_SPR, 8'hA5);
    i_usr_host_model.mute = 1'b0;
    rchk(usr_pkg::OFF_SPR, 8'h5A);
    wr(usr_pkg::OFF_LCR, 8'h80);
    rchk(3'h0, REV_V);
    rchk(3'h1, ID_V);
    wr(3'h0, 8'h12);
    rchk(3'h0, 8'h12);
    `CHK("divisor", 16'h0012, divisor);
    // enhanced bits locked, then opened
    wr(usr_pkg::OFF_LCR, 8'h00);
    wr(usr_pkg::OFF_IER, 8'hFF);
    rchk(usr_pkg::OFF_IER, 8'h0F);
    wr(usr_pkg::OFF_MCR, 8'hFF);
    `CHK("modem_ctrl", 8'h1F, modem_ctrl);
    wr(usr_pkg::OFF_LCR, 8'hBF);
    wr(3'h2, 8'h10);
    wr(3'h4, 8'h11);
    `CHK("line_ctrl", 8'hBF, line_ctrl);
    `CHK("enh_func", 8'h10, enh_func);
    `CHK("flow_chars", 32'h00000011, flow_chars);
    wr(usr_pkg::OFF_LCR, 8'h80);
    wr(3'h2, 8'h0F);
    `CHK("divisor_frac", 8'h0F, divisor_frac);
    wr(usr_pkg::OFF_LCR, 8'h00);
    wr(usr_pkg::OFF_IER, 8'hFF);
    rchk(usr_pkg::OFF_IER, 8'hFF);
    // fifo interrupt mode, trigger level 4
    wr(usr_pkg::OFF_ISR, 8'h71);
    `CHK("tx_trig_sel", 2'h3, tx_trig_sel);
    wr(usr_pkg::OFF_IER, 8'h01);
    for (int i = 0; i < 3; i++)
      push(8'h10 + 8'(i), 3'h0);
    irq_is(1'b0);
    rchk(usr_pkg::OFF_ISR, 8'hC1);
    push(8'h13, 3'h0);
    irq_is(1'b1);
    rchk(usr_pkg::OFF_ISR, 8'hC4);
    rchk(usr_pkg::OFF_DATA, 8'h10);
    irq_is(1'b0);
    rchk(usr_pkg::OFF_ISR, 8'hC1);
    // polled mode, error flags follow the head
    wr(usr_pkg::OFF_IER, 8'h00);
    wr(usr_pkg::OFF_ISR, 8'h43);
    rchk(usr_pkg::OFF_LSR, 8'h60);
    for (int i = 0; i < 4; i++)
      push(8'h20 + 8'(i), 3'((1 << i) >> 1));
    rchk(usr_pkg::OFF_LSR, 8'hE1);
    for (int i = 0; i < 4; i++)
    begin
      rchk(usr_pkg::OFF_LSR, 8'hE1 | 8'(((1 << i) >> 1) << 2));
      rchk(usr_pkg::OFF_DATA, 8'h20 + 8'(i));
    end
    rchk(usr_pkg::OFF_LSR, 8'h60);
    // overrun with the line source enabled
    wr(usr_pkg::OFF_IER, 8'h04);
    for (int i = 0; i < 17; i++)
      push(8'(i), 3'h0);
    irq_is(1'b1);
    rchk(usr_pkg::OFF_ISR, 8'hC6);
    rchk(usr_pkg::OFF_LSR, 8'h63);
    rchk(usr_pkg::OFF_LSR, 8'h61);
    irq_is(1'b0);
    wr(usr_pkg::OFF_ISR, 8'h43);
    // modem source gated by its enable
    wr(usr_pkg::OFF_IER, 8'h08);
    modem_stat = 8'h01;
    irq_is(1'b1);
    rchk(usr_pkg::OFF_ISR, 8'hC0);
    wr(usr_pkg::OFF_IER, 8'h00);
    irq_is(1'b0);
    modem_stat = 8'h00;
    // transmit empty source
    wr(usr_pkg::OFF_IER, 8'h02);
    tx_fifo_empty = 1'b0;
    @(negedge clk);
    tx_fifo_empty = 1'b1;
    irq_is(1'b1);
    rchk(usr_pkg::OFF_ISR, 8'hC2);
    irq_is(1'b0);
    report_and_stop();
  end
endmodule

// ### dv/usr_host_model.sv
// usr_host_model: host processor on the byte register bus
// assumes: device samples strobes on the rising edge, host moves on falling
`timescale 1ns/1ps
module usr_host_model (
  // clock
  input  wire logic       clk,
  // bus to device
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [2:0] addr,
  output logic      [7:0] wdata,
  input  wire logic [7:0] rdata
);
  // set by the bench to leave the channel unselected during writes; reads still select it
  logic mute = 1'b0;

  initial
  begin
    cs_n  = 1'b1;
    rd_n  = 1'b1;
    wr_n  = 1'b1;
    addr  = 3'h0;
    wdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // one write: strobe low one cycle, high at least one
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    cs_n  = mute;
    wr_n  = 1'b0;
    addr  = a;
    wdata = d;
    @(negedge clk);
    cs_n  = 1'b1;
    wr_n  = 1'b1;
    wdata = ~d;
  endtask

  // one read: data taken the cycle after the start edge
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk);
    cs_n = 1'b0;
    rd_n = 1'b0;
    addr = a;
    @(negedge clk);
    d    = rdata;
    cs_n = 1'b1;
    rd_n = 1'b1;
  endtask
endmodule

// ### rtl/usr_pkg.sv
// usr_pkg: register offsets, field positions, reset values, FIFO triggers
// assumes: one serial channel, byte-wide host bus, 3 address lines
package usr_pkg;
  // register offsets on a2..a0
  localparam logic [2:0] OFF_DATA  = 3'h0;
  localparam logic [2:0] OFF_IER   = 3'h1;
  localparam logic [2:0] OFF_ISR   = 3'h2;
  localparam logic [2:0] OFF_LCR   = 3'h3;
  localparam logic [2:0] OFF_MCR   = 3'h4;
  localparam logic [2:0] OFF_LSR   = 3'h5;
  localparam logic [2:0] OFF_MSR   = 3'h6;
  localparam logic [2:0] OFF_SPR   = 3'h7;
  // line control value that opens the enhanced set
  localparam logic [7:0] LCR_ENH   = 8'hBF;
  localparam int         LCR_DIV   = 7;
  localparam int         EFR_ENH   = 4;
  localparam int         FCR_EN    = 0;
  localparam int         FCR_RXRST = 1;
  localparam int         FCR_TXRST = 2;
  // bits of the enhanced-only fields
  localparam logic [7:0] IER_ENH_M = 8'hF0;
  localparam logic [7:0] FCR_ENH_M = 8'h30;
  localparam logic [7:0] MCR_ENH_M = 8'hE0;
  // reset values
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [7:0] RST_LCR   = 8'h00;
  // receive FIFO trigger levels for fifo control bits 7:6
  localparam logic [4:0] TRIG_0    = 5'h01;
  localparam logic [4:0] TRIG_1    = 5'h04;
  localparam logic [4:0] TRIG_2    = 5'h08;
  localparam logic [4:0] TRIG_3    = 5'h0E;
  // interrupt status codes on bits 3:0
  localparam logic [3:0] ISR_NONE  = 4'h1;
  localparam logic [3:0] ISR_LINE  = 4'h6;
  localparam logic [3:0] ISR_RXD   = 4'h4;
  localparam logic [3:0] ISR_TXE   = 4'h2;
  localparam logic [3:0] ISR_MDM   = 4'h0;
  // register selected by one access
  typedef enum logic [3:0] {
    SEL_DATA, SEL_IER, SEL_ISR, SEL_LCR, SEL_MCR, SEL_LSR, SEL_MSR,
    SEL_SPR, SEL_DLL, SEL_DLM, SEL_DLD, SEL_EFR, SEL_RESUME_CHAR_1, SEL_RESUME_CHAR_2,
    SEL_PAUSE_CHAR_1, SEL_PAUSE_CHAR_2
  } usr_sel_type;
endpackage

// ### rtl/usr_regs.sv
// usr_regs: register map, line status and receive interrupt reporting
// assumes: host strobes are synchronous to clk; receiver and transmitter
// datapaths live outside and talk through the rx_* and tx_* ports
//
// What this block does
// - with FIFOs and the receive interrupt enabled, receive status shows in status bits 2 and 3.
// - in FIFO mode the receive interrupt rises once the fill level reaches the trigger level.
// - the receive status drops once the fill level is below the trigger; irq drops only if no other enabled source is pending.
// - line status bit 0 sets when a byte enters the receive FIFO and clears only when empty.
// - clearing enable bits 0 to 3 gives polled operation through separate line status bits.
// - line status bit 1 flags a receive overrun.
// - line status bits 2 to 4 give parity, framing and break of the byte at the head.
// - bit 5 flags empty transmit holding, bit 6 only when holding and shift are both empty.
// - line status bit 7 is set while any byte in the receive FIFO carries an error.
// - the enable register gates the four interrupt sources reported in the status register.
// - enhanced bits are writable and effective only while enhanced bit 4 is set.
// - each channel has its own registers picked by three address lines and its select.
`timescale 1ns/1ps
module usr_regs #(
  parameter int         DEPTH   = 16,
  parameter logic [7:0] DEV_ID  = 8'hA5, // arbitrary value
  parameter logic [7:0] DEV_REV = 8'h01  // arbitrary value
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // host bus
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o,
  output logic            data_oe,
  output logic            irq,
  // receiver side
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_perr,
  input  wire logic       rx_ferr,
  input  wire logic       rx_brk,
  // transmitter side
  input  wire logic       tx_fifo_empty,
  input  wire logic       tx_shift_empty,
  output logic            tx_wr,
  output logic      [7:0] tx_data,
  output logic            tx_fifo_rst,
  // configuration out
  output logic      [7:0] line_ctrl,
  output logic      [7:0] modem_ctrl,
  output logic      [7:0] enh_func,
  output logic     [15:0] divisor,
  output logic      [7:0] divisor_frac,
  output logic      [1:0] tx_trig_sel,
  output logic     [31:0] flow_chars,
  // modem pins
  input  wire logic [7:0] modem_stat
);
  localparam int CW = $clog2(DEPTH + 1);

  logic [7:0]  ier_q, lcr_q, mcr_q, spr_q, fcr_q, efr_q;
  logic [7:0]  dll_q, dlm_q, dld_q, resume_char_1_q, resume_char_2_q, pause_char_1_q, pause_char_2_q;
  logic [7:0]  data_q;
  logic        rd_act_q, wr_act_q, ovr_q, txi_q, tx_empty_q;
  logic        rd_act, wr_act, rd_stb, wr_stb;
  logic        enh;
  logic        fifo_en;
  logic [7:0]  ier_eff;
  logic [10:0] head;
  logic [CW-1:0] cnt;
  logic        empty, full, any_err, ovr_ev, pop, rx_clr;
  logic [4:0]  trig;
  logic        rx_src, line_src, mdm_src;
  logic [3:0]  isr_code;
  logic [7:0]  lsr_v, isr_v, rd_v;
  usr_pkg::usr_sel_type sel;

  ////////////////////////////////////////////////////////////////////////
  // address decode and host strobes

  function automatic usr_pkg::usr_sel_type decode(
    input logic [2:0] a, input logic [7:0] lcr, input logic e);
    usr_pkg::usr_sel_type s;
    s = usr_pkg::usr_sel_type'({1'b0, a});
    if (lcr == usr_pkg::LCR_ENH)
    begin
      if (a == usr_pkg::OFF_DATA) s = usr_pkg::SEL_DLL;
      else if (a == usr_pkg::OFF_IER) s = usr_pkg::SEL_DLM;
      else if (a == usr_pkg::OFF_ISR) s = usr_pkg::SEL_EFR;
      else if (a == usr_pkg::OFF_MCR) s = usr_pkg::SEL_RESUME_CHAR_1;
      else if (a == usr_pkg::OFF_LSR) s = usr_pkg::SEL_RESUME_CHAR_2;
      else if (a == usr_pkg::OFF_MSR) s = usr_pkg::SEL_PAUSE_CHAR_1;
      else if (a == usr_pkg::OFF_SPR) s = usr_pkg::SEL_PAUSE_CHAR_2;
    end
    else if (lcr[usr_pkg::LCR_DIV])
    begin
      if (a == usr_pkg::OFF_DATA) s = usr_pkg::SEL_DLL;
      else if (a == usr_pkg::OFF_IER) s = usr_pkg::SEL_DLM;
      else if (a == usr_pkg::OFF_ISR && e) s = usr_pkg::SEL_DLD;
    end
    return s;
  endfunction

  assign enh    = efr_q[usr_pkg::EFR_ENH];
  assign rd_act = !cs_n && !rd_n;
  assign wr_act = !cs_n && !wr_n;
  assign rd_stb = rd_act && !rd_act_q;
  assign wr_stb = wr_act && !wr_act_q;
  assign sel    = decode(addr, lcr_q, enh);

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
    end
    else
    begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // writable registers

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ier_q   <= usr_pkg::RST_ZERO;
      lcr_q   <= usr_pkg::RST_LCR;
      mcr_q   <= usr_pkg::RST_ZERO;
      spr_q   <= usr_pkg::RST_ZERO;
      fcr_q   <= usr_pkg::RST_ZERO;
      efr_q   <= usr_pkg::RST_ZERO;
      dll_q   <= usr_pkg::RST_ZERO;
      dlm_q   <= usr_pkg::RST_ZERO;
      dld_q   <= usr_pkg::RST_ZERO;
      resume_char_1_q  <= usr_pkg::RST_ZERO;
      resume_char_2_q  <= usr_pkg::RST_ZERO;
      pause_char_1_q <= usr_pkg::RST_ZERO;
      pause_char_2_q <= usr_pkg::RST_ZERO;
    end
    else if (wr_stb)
    begin
      case (sel)
        usr_pkg::SEL_IER:
          ier_q <= enh ? data_i : {ier_q[7:4], data_i[3:0]};
        usr_pkg::SEL_ISR:
          // other bits take effect only with FIFOs enabled
          if (data_i[usr_pkg::FCR_EN])
          begin
            fcr_q <= enh ? data_i : {data_i[7:6], fcr_q[5:4], data_i[3:0]};
          end
          else
          begin
            fcr_q <= usr_pkg::RST_ZERO;
          end
        usr_pkg::SEL_LCR:   lcr_q <= data_i;
        usr_pkg::SEL_MCR:
          mcr_q <= enh ? data_i : {mcr_q[7:5], data_i[4:0]};
        usr_pkg::SEL_SPR:   spr_q   <= data_i;
        usr_pkg::SEL_DLL:   dll_q   <= data_i;
        usr_pkg::SEL_DLM:   dlm_q   <= data_i;
        usr_pkg::SEL_DLD:   dld_q   <= data_i;
        usr_pkg::SEL_EFR:   efr_q   <= data_i;
        usr_pkg::SEL_RESUME_CHAR_1:  resume_char_1_q  <= data_i;
        usr_pkg::SEL_RESUME_CHAR_2:  resume_char_2_q  <= data_i;
        usr_pkg::SEL_PAUSE_CHAR_1: pause_char_1_q <= data_i;
        usr_pkg::SEL_PAUSE_CHAR_2: pause_char_2_q <= data_i;
        default: ;
      endcase
    end
  end

  // self-clearing reset bits are seen as pulses
  assign fifo_en     = fcr_q[usr_pkg::FCR_EN];
  assign rx_clr      = wr_stb && sel == usr_pkg::SEL_ISR && data_i[usr_pkg::FCR_EN]
                       && data_i[usr_pkg::FCR_RXRST];
  assign tx_fifo_rst = wr_stb && sel == usr_pkg::SEL_ISR && data_i[usr_pkg::FCR_EN]
                       && data_i[usr_pkg::FCR_TXRST];
  assign tx_wr       = wr_stb && sel == usr_pkg::SEL_DATA;
  assign tx_data     = data_i;

  // enhanced fields read back but act only while enabled
  assign ier_eff      = enh ? ier_q : (ier_q & ~usr_pkg::IER_ENH_M);
  assign modem_ctrl   = enh ? mcr_q : (mcr_q & ~usr_pkg::MCR_ENH_M);
  assign divisor_frac = enh ? dld_q : usr_pkg::RST_ZERO;
  assign tx_trig_sel  = enh ? fcr_q[5:4] : 2'b00;
  assign line_ctrl    = lcr_q;
  assign enh_func     = efr_q;
  assign divisor      = {dlm_q, dll_q};
  assign flow_chars   = {pause_char_2_q, pause_char_1_q, resume_char_2_q, resume_char_1_q};

  ////////////////////////////////////////////////////////////////////////
  // receive FIFO and line status

  assign pop = rd_stb && sel == usr_pkg::SEL_DATA;

  usr_rx_fifo #(
    .DW    (11),
    .DEPTH (DEPTH),
    .CW    (CW)
  ) u_rx_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .clr       (rx_clr),
    .push      (rx_valid),
    .din       ({rx_brk, rx_ferr, rx_perr, rx_data}),
    .pop       (pop),
    .limit_one (!fifo_en),
    .head      (head),
    .count     (cnt),
    .empty     (empty),
    .full      (full),
    .any_err   (any_err),
    .overrun   (ovr_ev)
  );

  // overrun sticks until line status is read; a new one wins
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      ovr_q <= 1'b0;
    end
    else if (ovr_ev)
    begin
      ovr_q <= 1'b1;
    end
    else if (rd_stb && sel == usr_pkg::SEL_LSR)
    begin
      ovr_q <= 1'b0;
    end
  end

  assign lsr_v[0]   = !empty;
  assign lsr_v[1]   = ovr_q;
  assign lsr_v[4:2] = head[10:8];
  assign lsr_v[5]   = tx_fifo_empty;
  assign lsr_v[6]   = tx_fifo_empty && tx_shift_empty;
  assign lsr_v[7]   = any_err;

  ////////////////////////////////////////////////////////////////////////
  // interrupt sources and status

  function automatic logic [4:0] trig_level(input logic [1:0] s);
    logic [4:0] t;
    t = usr_pkg::TRIG_0;
    if (s == 2'd1) t = usr_pkg::TRIG_1;
    else if (s == 2'd2) t = usr_pkg::TRIG_2;
    else if (s == 2'd3) t = usr_pkg::TRIG_3;
    return t;
  endfunction

  assign trig = fifo_en ? trig_level(fcr_q[7:6]) : usr_pkg::TRIG_0;

  // transmit ready sticks until status read or holding write
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      // idle level of the empty flag, so no false edge after reset
      tx_empty_q <= 1'b1;
      txi_q      <= 1'b0;
    end
    else
    begin
      tx_empty_q <= tx_fifo_empty;
      if (tx_fifo_empty && !tx_empty_q)
      begin
        txi_q <= 1'b1;
      end
      else if (tx_wr || (rd_stb && sel == usr_pkg::SEL_ISR))
      begin
        txi_q <= 1'b0;
      end
    end
  end

  assign rx_src   = ier_eff[0] && (5'(cnt) >= trig);
  assign line_src = ier_eff[2] && (|lsr_v[4:1]);
  assign mdm_src  = ier_eff[3] && (|modem_stat[3:0]);

  always_comb
  begin
    isr_code = usr_pkg::ISR_NONE;
    if (line_src) isr_code = usr_pkg::ISR_LINE;
    else if (rx_src) isr_code = usr_pkg::ISR_RXD;
    else if (ier_eff[1] && txi_q) isr_code = usr_pkg::ISR_TXE;
    else if (mdm_src) isr_code = usr_pkg::ISR_MDM;
  end

  // bits 5:4 have no source in this block
  assign isr_v = {fifo_en, fifo_en, 2'b00, isr_code};
  // polled mode: enable bits 0-3 clear keeps irq low
  assign irq   = !isr_code[0];

  ////////////////////////////////////////////////////////////////////////
  // read data

  always_comb
  begin
    rd_v = usr_pkg::RST_ZERO;
    case (sel)
      usr_pkg::SEL_DATA: rd_v = head[7:0];
      usr_pkg::SEL_IER:  rd_v = ier_q;
      usr_pkg::SEL_ISR:  rd_v = isr_v;
      usr_pkg::SEL_LCR:  rd_v = lcr_q;
      usr_pkg::SEL_MCR:  rd_v = mcr_q;
      usr_pkg::SEL_LSR:  rd_v = lsr_v;
      usr_pkg::SEL_MSR:  rd_v = modem_stat;
      usr_pkg::SEL_SPR:  rd_v = spr_q;
      usr_pkg::SEL_DLL:
        rd_v = (dll_q == 8'h00 && dlm_q == 8'h00) ? DEV_REV : dll_q;
      usr_pkg::SEL_DLM:
        rd_v = (dll_q == 8'h00 && dlm_q == 8'h00) ? DEV_ID : dlm_q;
      usr_pkg::SEL_DLD:   rd_v = dld_q;
      usr_pkg::SEL_EFR:   rd_v = efr_q;
      usr_pkg::SEL_RESUME_CHAR_1:  rd_v = resume_char_1_q;
      usr_pkg::SEL_RESUME_CHAR_2:  rd_v = resume_char_2_q;
      usr_pkg::SEL_PAUSE_CHAR_1: rd_v = pause_char_1_q;
      usr_pkg::SEL_PAUSE_CHAR_2: rd_v = pause_char_2_q;
      default: ;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      data_q <= usr_pkg::RST_ZERO;
    end
    else if (rd_stb)
    begin
      data_q <= rd_v;
    end
  end

  assign data_o  = data_q;
  assign data_oe = rd_act && rd_act_q;

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_rx_status;
    @(posedge clk) disable iff (!rstn)
    (fifo_en && ier_q[0] && !line_src && 5'(cnt) >= trig) |-> isr_v[3:2] == 2'b01;
  endproperty
  a_rx_status: assert property (p_rx_status) else $error("rx status missing");

  property p_rx_raise;
    @(posedge clk) disable iff (!rstn)
    (fifo_en && ier_q[0] && 5'(cnt) >= trig) |-> irq;
  endproperty
  a_rx_raise: assert property (p_rx_raise) else $error("rx irq not raised");

  property p_rx_drop;
    @(posedge clk) disable iff (!rstn)
    (fifo_en && ier_q[3:1] == 3'b000 && 5'(cnt) < trig) |-> !irq;
  endproperty
  a_rx_drop: assert property (p_rx_drop) else $error("rx irq stuck");

  property p_ready_set;
    @(posedge clk) disable iff (!rstn)
    (rx_valid && !full && !rx_clr) |=> lsr_v[0];
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready not set");

  property p_polled;
    @(posedge clk) disable iff (!rstn)
    (ier_q[3:0] == 4'h0) |-> !irq;
  endproperty
  a_polled: assert property (p_polled) else $error("irq in polled mode");

  property p_overrun;
    @(posedge clk) disable iff (!rstn)
    (rx_valid && full) |=> lsr_v[1] [*2];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun lost");

  property p_tx_empty;
    @(posedge clk) disable iff (!rstn)
    lsr_v[6] |-> lsr_v[5] && tx_shift_empty;
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx empty wrong");

  property p_err_seen;
    @(posedge clk) disable iff (!rstn)
    (empty && rx_valid && (rx_perr || rx_ferr || rx_brk) && !rx_clr)
      |=> lsr_v[7] && (lsr_v[4:2] != 3'b000);
  endproperty
  a_err_seen: assert property (p_err_seen) else $error("rx error not shown");

  property p_enh_lock;
    @(posedge clk) disable iff (!rstn)
    (wr_stb && !enh && sel == usr_pkg::SEL_IER) |=> $stable(ier_q[7:4]);
  endproperty
  a_enh_lock: assert property (p_enh_lock) else $error("enhanced bits written");

  property p_lsr_read;
    @(posedge clk) disable iff (!rstn)
    (rd_stb && sel == usr_pkg::SEL_LSR && !rx_valid && !rx_clr) |=> $stable(cnt);
  endproperty
  a_lsr_read: assert property (p_lsr_read) else $error("lsr read moved fifo");

  property p_cov_rx;
    @(posedge clk) disable iff (!rstn)
    fifo_en && rx_src ##1 !rx_src;
  endproperty
  c_cov_rx: cover property (p_cov_rx);

  property p_cov_ovr;
    @(posedge clk) disable iff (!rstn)
    rx_valid && full;
  endproperty
  c_cov_ovr: cover property (p_cov_ovr);

  property p_cov_enh;
    @(posedge clk) disable iff (!rstn)
    wr_stb && enh && sel == usr_pkg::SEL_IER;
  endproperty
  c_cov_enh: cover property (p_cov_enh);
endmodule

// ### rtl/usr_rx_fifo.sv
// usr_rx_fifo: receive FIFO holding each byte with its three error flags
// assumes: push and pop are one-cycle pulses, push on full is dropped
`timescale 1ns/1ps
module usr_rx_fifo #(
  parameter int DW    = 11,
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // control
  input  wire logic          clr,
  input  wire logic          push,
  input  wire logic [DW-1:0] din,
  input  wire logic          pop,
  input  wire logic          limit_one,
  // state
  output logic      [DW-1:0] head,
  output logic      [CW-1:0] count,
  output logic               empty,
  output logic               full,
  output logic               any_err,
  output logic               overrun
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [DW-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] err_q;
  logic          do_push;
  logic          do_pop;
  logic          in_err;
  logic          out_err;

  assign empty   = (cnt_q == '0);
  // non-FIFO mode holds one byte only
  assign full    = limit_one ? !empty : (cnt_q == CW'(DEPTH));
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign overrun = push && full;
  assign head    = empty ? '0 : mem_q[rd_q];
  assign count   = cnt_q;
  assign in_err  = |din[DW-1:DW-3];
  assign out_err = |head[DW-1:DW-3];
  assign any_err = (err_q != '0);

  always_ff @(posedge clk)
  begin
    if (do_push)
    begin
      mem_q[wr_q] <= din;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn || clr)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
      err_q <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_q <= wr_q + AW'(1);
      end
      if (do_pop)
      begin
        rd_q <= rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (do_push ? ONE : '0) - (do_pop ? ONE : '0);
      err_q <= err_q + ((do_push && in_err) ? ONE : '0)
                     - ((do_pop && out_err) ? ONE : '0);
    end
  end
endmodule
